//--- lgcr_top.sv
// global control registers, segment-eight amplitudes and master clock timing
`timescale 1ns/100ps
`include "lgcr_map.svh"
module lgcr_top
    import lgcr_pkg::*;
#(
    parameter int NCH = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // parallel host port
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_oe,
    // per-channel line status
    input wire logic [NCH-1:0] arb_mode_ch,
    input wire logic [NCH-1:0] rx_signal_loss,
    input wire logic [NCH-1:0] ch_irq_req,
    // pulse shaper timing and amplitude
    output logic seg_tick,
    output logic [2:0] seg_index,
    output logic mclk_tick,
    output logic [NCH-1:0] seg8_active,
    output logic [NCH*`LGCR_SEG_W-1:0] seg8_amp,
    // global line configuration
    output logic rail_mode_select,
    output logic auto_ones_on_signal_loss,
    output logic rx_output_edge_select,
    output logic tx_sample_edge_select,
    output logic data_polarity_select,
    output logic [NCH-1:0] tx_all_ones,
    output logic irq,
    output logic core_reset_n,
    // clock synthesizer control
    output logic [2:0] clock_select_bits,
    output logic master_clock_rate_bit,
    output logic pll_retune,
    output logic clk_sel_both_changed
);
    localparam int SW = `LGCR_SEG_W;
    localparam logic [`LGCR_ACC_W-1:0] INC_E1 = `LGCR_ACC_W'(`LGCR_SEG_INC(`LGCR_MCLK_E1_KHZ));
    localparam logic [`LGCR_ACC_W-1:0] INC_T1 = `LGCR_ACC_W'(`LGCR_SEG_INC(`LGCR_MCLK_T1_KHZ));
    localparam logic [`LGCR_SRST_CNT_W-1:0] SRST_CYC = `LGCR_SRST_CNT_W'(`LGCR_SRST_CYC);

    // signed magnitude to two's complement
    function automatic logic [SW-1:0] sm_to_tc(input logic [SW-1:0] v);
        logic [SW-1:0] mag;
        mag = {1'b0, v[SW-2:0]};
        sm_to_tc = v[`LGCR_SEG_SIGN] ? SW'(-mag) : mag;
    endfunction

    // host strobes
    logic wr_act_q;
    logic [7:0] addr_q;
    wire wr_act = !cs_n && !wr_n;
    wire rd_act = !cs_n && !rd_n;
    wire wr_go = wr_act && !wr_act_q;

    // address decode
    wire hit_seg8 = !addr[7] && (addr[3:0] == `LGCR_SEG8_LOW_NIB);
    wire hit_glc = (addr == `LGCR_GLC_ADDR);
    wire hit_css = (addr == `LGCR_CSS_ADDR);
    wire q_seg8 = !addr_q[7] && (addr_q[3:0] == `LGCR_SEG8_LOW_NIB);
    wire q_glc = (addr_q == `LGCR_GLC_ADDR);
    wire q_css = (addr_q == `LGCR_CSS_ADDR);

    // registers
    logic [7:0] glc_r;
    logic [7:0] css_r;
    logic [SW-1:0] seg_rd;
    logic [NCH*SW-1:0] seg_all;

    wire seg_we = wr_go && hit_seg8;
    wire glc_we = wr_go && hit_glc;
    wire css_we = wr_go && hit_css;
    wire [7:0] glc_nxt = data_in & `LGCR_GLC_WMASK;
    wire [7:0] css_nxt = data_in & `LGCR_CSS_WMASK;
    wire [7:0] css_diff = css_nxt ^ css_r;
    wire freq_change = css_we &&
        ((css_diff[`LGCR_CSS_SEL_HI:`LGCR_CSS_SEL_LO] != 3'h0) ||
         css_diff[`LGCR_CSS_RATE]);
    // host should split the halves into two writes; flag it when not
    wire both_halves = css_we && ((css_diff & `LGCR_CSS_UPPER) != 8'h00) &&
        ((css_diff & `LGCR_CSS_LOWER) != 8'h00);

    lgcr_seg_mem #(
        .WORDS(NCH),
        .WIDTH(SW),
        .AW(3)
    ) u_seg_mem (
        .clk(clk),
        .resetn(resetn),
        .wr_en(seg_we),
        .wr_addr(addr[6:4]),
        .wr_data(data_in[SW-1:0]),
        .rd_addr(addr[6:4]),
        .rd_data(seg_rd),
        .all_data(seg_all)
    );

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_act_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_act_q <= wr_act;
            addr_q <= addr;
        end
    end

    // control registers stay untouched by the soft reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            glc_r <= `LGCR_GLC_RESET;
        end else if (glc_we) begin
            glc_r <= glc_nxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            css_r <= `LGCR_CSS_RESET;
        end else if (css_we) begin
            css_r <= css_nxt;
        end
    end

    // read path, aligned with the registered memory read
    wire [7:0] rd_mux = q_seg8 ? {1'b0, seg_rd} :
                        q_glc ? glc_r :
                        q_css ? css_r : 8'h00;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            data_out <= 8'h00;
        end else if (rd_act) begin
            data_out <= rd_mux;
        end
    end

    assign data_oe = rd_act;

    // soft reset: armed by the bit, asserted once held past the minimum time
    lgcr_srst_t srst_state_r;
    lgcr_srst_t srst_state_nxt;
    logic [`LGCR_SRST_CNT_W-1:0] srst_cnt_r;
    logic [`LGCR_SRST_CNT_W-1:0] srst_cnt_nxt;
    wire srst_bit = glc_r[`LGCR_GLC_SRST];

    always_comb begin
        srst_state_nxt = srst_state_r;
        srst_cnt_nxt = srst_cnt_r;
        case (srst_state_r)
            LGCR_SRST_IDLE: begin
                srst_cnt_nxt = '0;
                if (srst_bit) begin
                    srst_state_nxt = LGCR_SRST_ARM;
                end
            end
            LGCR_SRST_ARM: begin
                if (!srst_bit) begin
                    srst_state_nxt = LGCR_SRST_IDLE;
                end else if (srst_cnt_r == SRST_CYC) begin
                    srst_state_nxt = LGCR_SRST_HOLD;
                end else begin
                    srst_cnt_nxt = srst_cnt_r + 1'b1;
                end
            end
            LGCR_SRST_HOLD: begin
                if (!srst_bit) begin
                    srst_state_nxt = LGCR_SRST_IDLE;
                end
            end
            default: begin
                srst_state_nxt = LGCR_SRST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            srst_state_r <= LGCR_SRST_IDLE;
            srst_cnt_r <= '0;
        end else begin
            srst_state_r <= srst_state_nxt;
            srst_cnt_r <= srst_cnt_nxt;
        end
    end

    wire core_hold = (srst_state_r == LGCR_SRST_HOLD);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            core_reset_n <= 1'b0;
        end else begin
            core_reset_n <= !core_hold;
        end
    end

    // segment timer: eight ticks per master clock period
    logic [`LGCR_ACC_W-1:0] acc_r;
    logic [2:0] seg_idx_r;
    wire [`LGCR_ACC_W-1:0] seg_inc = css_r[`LGCR_CSS_RATE] ? INC_T1 : INC_E1;
    wire [`LGCR_ACC_W:0] acc_sum = {1'b0, acc_r} + {1'b0, seg_inc};
    wire acc_carry = acc_sum[`LGCR_ACC_W];
    wire timer_clear = core_hold || freq_change;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_r <= '0;
            seg_idx_r <= 3'h0;
        end else if (timer_clear) begin
            acc_r <= '0;
            seg_idx_r <= 3'h0;
        end else begin
            acc_r <= acc_sum[`LGCR_ACC_W-1:0];
            if (acc_carry) begin
                seg_idx_r <= seg_idx_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            seg_tick <= 1'b0;
            mclk_tick <= 1'b0;
        end else begin
            seg_tick <= acc_carry && !timer_clear;
            mclk_tick <= acc_carry && !timer_clear && (seg_idx_r == `LGCR_LAST_SEG);
        end
    end

    assign seg_index = seg_idx_r;

    // retune and split-write indications
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pll_retune <= 1'b0;
            clk_sel_both_changed <= 1'b0;
        end else begin
            pll_retune <= freq_change;
            clk_sel_both_changed <= both_halves;
        end
    end

    assign clock_select_bits = css_r[`LGCR_CSS_SEL_HI:`LGCR_CSS_SEL_LO];
    assign master_clock_rate_bit = css_r[`LGCR_CSS_RATE];

    // global line configuration
    assign rail_mode_select = glc_r[`LGCR_GLC_RAIL];
    assign auto_ones_on_signal_loss = glc_r[`LGCR_GLC_AUTO1];
    assign rx_output_edge_select = glc_r[`LGCR_GLC_RXEDGE];
    assign tx_sample_edge_select = glc_r[`LGCR_GLC_TXEDGE];
    assign data_polarity_select = glc_r[`LGCR_GLC_POL];

    wire irq_any = glc_r[`LGCR_GLC_GIE] && (|ch_irq_req) && !core_hold;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_any;
        end
    end

    // per-channel shaping and all-ones substitution
    wire in_last_seg = (seg_idx_r == `LGCR_LAST_SEG) && !core_hold;

    genvar gc;
    generate
        for (gc = 0; gc < NCH; gc++) begin : g_ch
            wire shape_on = in_last_seg && arb_mode_ch[gc];
            wire ones_on = glc_r[`LGCR_GLC_AUTO1] && rx_signal_loss[gc] && !core_hold;
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    seg8_active[gc] <= 1'b0;
                    seg8_amp[gc*SW +: SW] <= '0;
                    tx_all_ones[gc] <= 1'b0;
                end else begin
                    seg8_active[gc] <= shape_on;
                    seg8_amp[gc*SW +: SW] <= shape_on ?
                        sm_to_tc(seg_all[gc*SW +: SW]) : '0;
                    tx_all_ones[gc] <= ones_on;
                end
            end
        end
    endgenerate
endmodule

//--- lgcr_map.svh
// register offsets, field positions, reset values and timing counts of the global control block
// Functional notes
// - every channel keeps its own 7-bit amplitude for segment eight.
// - the amplitude is signed magnitude, top bit sign, bit 0 the lsb.
// - eight back-to-back segments together span one master clock period.
// - segment amplitude shapes a channel only while that channel is in arbitrary mode.
// - control bit 7 set selects single rail for all channels, clear dual rail.
// - control bit 6 set sends all ones on any channel losing receive signal.
// - control bit 5 set updates receive data on falling receive clock edge.
// - control bit 4 clear samples transmit data on falling transmit clock edge.
// - control bit 3 set makes transmit and receive data active low.
// - control bit 1 gates interrupt generation for all channels.
// - host holds bit 0 high over 10 us, then the device starts its reset.
// - while bit 0 is high, internal circuits stay reset, registers keep values.
// - timing follows clock select and rate bits; a change retunes the synthesizer. The segment timer here follows the rate bit only.
`ifndef LGCR_MAP_SVH
`define LGCR_MAP_SVH

// register offsets
`define LGCR_SEG8_LOW_NIB 4'hF
`define LGCR_GLC_ADDR 8'h80
`define LGCR_CSS_ADDR 8'h81

// segment amplitude register
`define LGCR_SEG_W 7
`define LGCR_SEG_SIGN 6
`define LGCR_SEG_RESET 7'h00

// global line control fields
`define LGCR_GLC_RAIL 7
`define LGCR_GLC_AUTO1 6
`define LGCR_GLC_RXEDGE 5
`define LGCR_GLC_TXEDGE 4
`define LGCR_GLC_POL 3
`define LGCR_GLC_GIE 1
`define LGCR_GLC_SRST 0
`define LGCR_GLC_WMASK 8'hFB
`define LGCR_GLC_RESET 8'h00

// clock source select fields
`define LGCR_CSS_WMASK 8'h7F
`define LGCR_CSS_RESET 8'h00
`define LGCR_CSS_UPPER 8'hF8
`define LGCR_CSS_LOWER 8'h07
`define LGCR_CSS_SEL_HI 6
`define LGCR_CSS_SEL_LO 4
`define LGCR_CSS_RATE 0

// timing
`define LGCR_CLK_NS 8
`define LGCR_CLK_KHZ 64'd125000
`define LGCR_MCLK_E1_KHZ 64'd2048
`define LGCR_MCLK_T1_KHZ 64'd1544
`define LGCR_SEGS 64'd8
`define LGCR_LAST_SEG 3'h7
`define LGCR_ACC_W 24
`define LGCR_SEG_INC(khz) (((khz) * `LGCR_SEGS * (64'd1 << `LGCR_ACC_W)) / `LGCR_CLK_KHZ)
`define LGCR_SRST_NS 10000
`define LGCR_SRST_CYC ((`LGCR_SRST_NS + `LGCR_CLK_NS - 1) / `LGCR_CLK_NS)
`define LGCR_SRST_CNT_W 12

`endif

//--- lgcr_pkg.sv
// types shared by the global control block
package lgcr_pkg;
    typedef enum logic [1:0] {
        LGCR_SRST_IDLE,
        LGCR_SRST_ARM,
        LGCR_SRST_HOLD
    } lgcr_srst_t;
endpackage

//--- lgcr_seg_mem.sv
// per-channel store of segment-eight amplitudes with registered host read
`timescale 1ns/100ps
module lgcr_seg_mem #(
    parameter int WORDS = 8,
    parameter int WIDTH = 7,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    // read port
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data,
    // every word at once for the shaper
    output logic [WORDS*WIDTH-1:0] all_data
);
    logic [WIDTH-1:0] word_r [WORDS];

    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_word
            wire word_we = wr_en && (wr_addr == AW'(gi));
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    word_r[gi] <= '0;
                end else if (word_we) begin
                    word_r[gi] <= wr_data;
                end
            end
            assign all_data[gi*WIDTH +: WIDTH] = word_r[gi];
        end
    endgenerate

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= word_r[rd_addr];
        end
    end
endmodule

//--- lgcr_top_assertions.sv
// assertion checker for the global control register block
`timescale 1ns/100ps
`include "lgcr_map.svh"
module lgcr_top_checker #(
    parameter int NCH = 8
) (
    // clock, reset and host port
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] addr,
    input wire logic data_oe,
    // channel status
    input wire logic [NCH-1:0] arb_mode_ch,
    input wire logic [NCH-1:0] rx_signal_loss,
    input wire logic [NCH-1:0] ch_irq_req,
    // watched outputs
    input wire logic [2:0] seg_index,
    input wire logic [NCH-1:0] seg8_active,
    input wire logic [NCH*`LGCR_SEG_W-1:0] seg8_amp,
    input wire logic rail_mode_select,
    input wire logic auto_ones_on_signal_loss,
    input wire logic rx_output_edge_select,
    input wire logic tx_sample_edge_select,
    input wire logic data_polarity_select,
    input wire logic [NCH-1:0] tx_all_ones,
    input wire logic irq,
    input wire logic core_reset_n,
    input wire logic [2:0] clock_select_bits,
    input wire logic master_clock_rate_bit,
    input wire logic pll_retune,
    input wire logic clk_sel_both_changed
);
    wire logic w80 = !cs_n && !wr_n && addr == 8'h80;
    wire logic w81 = !cs_n && !wr_n && addr == 8'h81;
    wire logic [4:0] cfg = {rail_mode_select, auto_ones_on_signal_loss,
        rx_output_edge_select, tx_sample_edge_select, data_polarity_select};
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // core out of soft reset for three samples
    sequence s_up;
        core_reset_n && $past(core_reset_n) && $past(core_reset_n, 2);
    endsequence
    sequence s_w81;
        $past(w81) || $past(w81, 2);
    endsequence
    property p_oe; data_oe == (!cs_n && !rd_n); endproperty
    a_oe: assert property (p_oe) else $error("read enable wrong");
    property p_all1; s_up |-> tx_all_ones ==
        ($past(rx_signal_loss) & {NCH{$past(auto_ones_on_signal_loss)}}); endproperty
    a_all1: assert property (p_all1) else $error("all ones wrong");
    property p_seg8; s_up |-> seg8_active ==
        ($past(arb_mode_ch) & {NCH{$past(seg_index) == 3'h7}}); endproperty
    a_seg8: assert property (p_seg8) else $error("seg8 active wrong");
    property p_amp; seg8_active == '0 |-> seg8_amp == '0; endproperty
    a_amp: assert property (p_amp) else $error("amp while idle");
    property p_idx; s_up ##0 $changed(seg_index) |->
        seg_index == $past(seg_index) + 3'h1 || seg_index == 3'h0; endproperty
    a_idx: assert property (p_idx) else $error("segment order");
    property p_retune; pll_retune |-> s_w81 ##0 !$past(pll_retune); endproperty
    a_retune: assert property (p_retune) else $error("stray retune");
    property p_both; clk_sel_both_changed |-> s_w81; endproperty
    a_both: assert property (p_both) else $error("stray both flag");
    property p_sel; $changed({clock_select_bits, master_clock_rate_bit}) |-> s_w81; endproperty
    a_sel: assert property (p_sel) else $error("select moved");
    property p_cfg; $changed(cfg) |-> $past(w80) || $past(w80, 2); endproperty
    a_cfg: assert property (p_cfg) else $error("config moved");
    property p_irq; irq |-> $past(|ch_irq_req); endproperty
    a_irq: assert property (p_irq) else $error("irq without request");
endmodule
bind lgcr_top lgcr_top_checker #(.NCH(NCH)) u_chk (.*);

//--- lgcr_host.sv
// host processor model on the parallel register port
`timescale 1ns/100ps
module lgcr_host (
    // clock
    input wire logic clk,
    // host port
    output logic cs_n = 1'b1,
    output logic rd_n = 1'b1,
    output logic wr_n = 1'b1,
    output logic [7:0] addr = 8'h00,
    output logic [7:0] data_in = 8'h00,
    input wire logic [7:0] data_out
);
    // one whole-register write, strobe released a cycle after
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        wr_n <= 1'b0;
        addr <= a;
        data_in <= d;
        @(posedge clk);
        cs_n <= 1'b1;
        wr_n <= 1'b1;
        data_in <= ~d;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        addr <= a;
        repeat (2) @(posedge clk);
        @(negedge clk);
        d = data_out;
        @(posedge clk);
        cs_n <= 1'b1;
        rd_n <= 1'b1;
    endtask
endmodule

//--- tb_liu_global_control_regs.sv
// self-checking bench for the global control register block
`timescale 1ns/100ps
`include "lgcr_map.svh"
module tb_liu_global_control_regs;
    localparam int NCH = 8;
    logic clk, resetn, cs_n, rd_n, wr_n, data_oe, seg_tick, mclk_tick, irq, core_reset_n;
    logic rail_mode_select, auto_ones_on_signal_loss, rx_output_edge_select;
    logic tx_sample_edge_select, data_polarity_select, master_clock_rate_bit;
    logic pll_retune, clk_sel_both_changed;
    logic [7:0] addr, data_in, data_out, rv, d;
    logic [NCH-1:0] arb_mode_ch, rx_signal_loss, ch_irq_req, seg8_active, tx_all_ones;
    logic [2:0] seg_index, clock_select_bits;
    logic [NCH*`LGCR_SEG_W-1:0] seg8_amp;
    int mismatches = 0;
    int cmp_count = 0;
    int seed = 35;
    int retunes = 0;
    int both_cnt = 0;
    wire logic [4:0] cfg = {rail_mode_select, auto_ones_on_signal_loss,
        rx_output_edge_select, tx_sample_edge_select, data_polarity_select};
    lgcr_top #(.NCH(NCH)) dut (.*);
    lgcr_host host (.*);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // one-cycle synthesizer pulses, counted where they stand
    always @(negedge clk) begin
        if (pll_retune === 1'b1)
            retunes++;
        if (clk_sel_both_changed === 1'b1)
            both_cnt++;
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        if (mismatches == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wrchk(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m);
        host.wr(a, v);
        host.rd(a, rv);
        chk(rv, v & m);
    endtask
    function automatic logic [6:0] sm2tc(input logic [6:0] v);
        return v[6] ? 7'(-{1'b0, v[5:0]}) : {1'b0, v[5:0]};
    endfunction
    // cycles and segments of one master clock period
    task automatic mperiod(input int lo);
        int cyc = 0;
        int segs = 0;
        while (mclk_tick !== 1'b1 && cyc < 300) begin
            @(negedge clk);
            cyc++;
        end
        cyc = 0;
        do begin
            @(negedge clk);
            cyc++;
            segs += seg_tick;
        end while (mclk_tick !== 1'b1 && cyc < 300);
        chk(cyc >= lo && cyc <= lo + 1, 1);
        chk(segs, 8);
    endtask
    initial begin
        resetn = 1'b0;
        arb_mode_ch = '0;
        rx_signal_loss = '0;
        ch_irq_req = '0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            host.rd(i == 0 ? 8'h0F : 8'h80 + 8'(i - 1), rv);
            chk(rv, 8'h00);
        end
        for (int c = 0; c < NCH; c++) begin
            d = c == 0 ? 8'hC0 : c == 1 ? 8'hFF : 8'($random(seed));
            wrchk({c[2:0], 4'hF}, d, 8'h7F);
            @(posedge clk);
            arb_mode_ch <= 8'h01 << c;
            for (int k = 0; k < 200 && seg8_active[c] !== 1'b1; k++)
                @(negedge clk);
            chk(seg8_active, 8'h01 << c);
            chk(seg8_amp[c*7 +: 7], sm2tc(d[6:0]));
        end
        @(posedge clk);
        arb_mode_ch <= '0;
        for (int i = 0; i < 8; i++) begin
            d = i == 0 ? 8'hFE : i == 1 ? 8'h00 : 8'($random(seed)) & 8'hFE;
            wrchk(8'h80, d, 8'hFB);
            @(posedge clk);
            rx_signal_loss <= 8'($random(seed));
            ch_irq_req <= i == 0 ? 8'h80 : 8'($random(seed));
            repeat (3) @(negedge clk);
            chk(cfg, d[7:3]);
            chk(irq, d[1] & |ch_irq_req);
            chk(tx_all_ones, rx_signal_loss & {NCH{d[6]}});
        end
        wrchk(8'h81, 8'h01, 8'h7F);
        chk(master_clock_rate_bit, 1);
        mperiod(int'(`LGCR_CLK_KHZ / `LGCR_MCLK_T1_KHZ));
        wrchk(8'h81, 8'hB1, 8'h7F);
        chk(clock_select_bits, 3'h3);
        wrchk(8'h81, 8'h30, 8'h7F);
        wrchk(8'h81, 8'h08, 8'h7F);
        wrchk(8'h81, 8'h09, 8'h7F);
        wrchk(8'h81, 8'h01, 8'h7F);
        wrchk(8'h81, 8'h00, 8'h7F);
        chk(retunes, 6);
        chk(both_cnt, 0);
        mperiod(int'(`LGCR_CLK_KHZ / `LGCR_MCLK_E1_KHZ));
        wrchk(8'h55, 8'hA5, 8'h00);
        host.wr(8'h80, 8'h41);
        @(posedge clk);
        rx_signal_loss <= 8'hFF;
        repeat (1235) @(negedge clk);
        chk(core_reset_n, 1);
        repeat (40) @(negedge clk);
        chk(core_reset_n, 0);
        chk(tx_all_ones, 8'h00);
        host.rd(8'h80, rv);
        chk(rv, 8'h41);
        host.wr(8'h80, 8'h40);
        repeat (3) @(negedge clk);
        chk(core_reset_n, 1);
        chk(tx_all_ones, 8'hFF);
        close_out;
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        close_out;
    end
endmodule
